//--- hw/pvft_source.sv
`timescale 1ns/1ps
// How it works
// - Frame sync high for one whole line
// - First active line two lines after sync
// - One line gap before next frame sync
// - Vertical blanking at least six plus eight-scaled
// - Line sync high four to 128 clocks
// - Four clocks line sync rise to valid
// - Eight clocks valid fall to line sync
// - Line length from pixel clock and rate
// - Blanking must cover both horizontal porches
// - Hold controller reset low 1.25 us
module pvft_source (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [pvft_pkg::DATA_W-1:0]  pixData,
  input  wire logic                         pixValid,
  output      logic                         pixReady,
  output      logic                         pixClkOut,
  output      pvft_pkg::pvft_pins_t         videoOut,
  output      logic                         resetInN,
  output      logic                         underrun
);

  // Sequencer states
  typedef enum logic [1:0] {
    PVFT_HOLD = 2'b00,                            // Controller held in reset
    PVFT_RUN  = 2'b01                             // Frames being sent
  } pvft_state_t;

  pvft_state_t                state_ff;           // Sequencer state
  logic [15:0]                rstCnt_ff;          // Reset low time counter
  logic                       resetInN_ff;        // Reset to controller
  logic                       pixClk_ff;          // Divided pixel clock
  logic                       tick;               // Pixel clock about to fall
  logic [15:0]                hCnt_ff;            // Pixel position in line
  logic [15:0]                vCnt_ff;            // Line position in frame
  logic [15:0]                nxt_h;
  logic [15:0]                nxt_v;
  pvft_pkg::pvft_pins_t       video_ff;           // Registered pins
  pvft_pkg::pvft_pins_t       nxt_video;
  logic                       underrun_ff;        // Sticky buffer underrun
  logic [pvft_pkg::DATA_W-1:0] bufData;
  logic                       bufValid;
  logic                       bufPop;
  logic                       running;

  // All checks below run on the system clock and rest during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // Span decode, shared by every sync and strobe
  function automatic logic inSpan(input logic [15:0] pos, input logic [15:0] lo,
                                  input logic [15:0] len);
    inSpan = (pos >= lo) && (pos < 16'(lo + len));
  endfunction : inSpan

  // Data buffer; a stall by the link side pushes back on the pixel source
  pvft_buf #(
    .WIDTH (pvft_pkg::DATA_W),
    .DEPTH (pvft_pkg::BUF_DEPTH)
  ) u_buf (
    .clk      (clk),
    .nrst     (nrst),
    .inData   (pixData),
    .inValid  (pixValid),
    .inReady  (pixReady),
    .outData  (bufData),
    .outValid (bufValid),
    .outReady (bufPop)
  );

  assign running = (state_ff == PVFT_RUN);
  assign tick    = pixClk_ff;                      // Next edge drives pixel clock low

  // Reset sequencer: release only after the least low time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff    <= PVFT_HOLD;
      rstCnt_ff   <= 16'h0000;
      resetInN_ff <= 1'b0;
    end else begin
      case (state_ff)
        PVFT_HOLD: begin
          rstCnt_ff <= 16'(rstCnt_ff + 16'h0001);
          if (rstCnt_ff == 16'(pvft_pkg::RST_CYC - 16'h0001)) begin
            resetInN_ff <= 1'b1;
            state_ff    <= PVFT_RUN;
          end
        end
        PVFT_RUN: begin
          resetInN_ff <= 1'b1;                     // Stays released
        end
        default: begin
          state_ff    <= PVFT_HOLD;
          resetInN_ff <= 1'b0;
        end
      endcase
    end
  end

  // Pixel clock divider; runs free once nrst is high, so the controller sees a clock in both sequencer states
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pixClk_ff <= 1'b0;
    end else begin
      pixClk_ff <= ~pixClk_ff;
    end
  end

  // Next raster position, line length fixed by clock and line rate
  always_comb begin
    nxt_h = 16'(hCnt_ff + 16'h0001);
    nxt_v = vCnt_ff;
    if (hCnt_ff >= 16'(pvft_pkg::H_TOTAL - 16'h0001)) begin
      nxt_h = 16'h0000;
      nxt_v = (vCnt_ff >= 16'(pvft_pkg::V_TOTAL - 16'h0001)) ? 16'h0000
                                                                : 16'(vCnt_ff + 16'h0001);
    end
  end

  // Raster counters; parked on the last pixel so the first frame opens cleanly
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hCnt_ff <= 16'(pvft_pkg::H_TOTAL - 16'h0001);
      vCnt_ff <= 16'(pvft_pkg::V_TOTAL - 16'h0001);
    end else if (tick && running) begin
      hCnt_ff <= nxt_h;
      vCnt_ff <= nxt_v;
    end
  end

  // Pin values for the coming pixel period
  always_comb begin
    nxt_video              = '0;
    // Frame sync covers whole lines starting with line zero
    nxt_video.frameSync    = running && inSpan(nxt_v, 16'h0000, pvft_pkg::VSW);
    nxt_video.lineSync     = running && inSpan(nxt_h, 16'h0000, pvft_pkg::HSW);
    // Active window sits after back porch in both axes
    nxt_video.pixelValidIn = running
                             && inSpan(nxt_v, pvft_pkg::VBP, pvft_pkg::ACT_LINES)
                             && inSpan(nxt_h, pvft_pkg::HBP, pvft_pkg::ACTIVE_PIXELS_PER_LINE);
    nxt_video.data         = (nxt_video.pixelValidIn && bufValid) ? bufData : '0;
  end

  // One word leaves the buffer per valid pixel period
  assign bufPop = tick && nxt_video.pixelValidIn;

  // Pins change as pixel clock falls, giving half a period before the rising sample
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      video_ff <= '0;
    end else if (tick) begin
      video_ff <= nxt_video;
    end
  end

  // Underrun: valid pixel sent with no buffered word; it stays until reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      underrun_ff <= 1'b0;
    end else if (bufPop && !bufValid) begin
      underrun_ff <= 1'b1;
    end
  end

  assign pixClkOut = pixClk_ff;
  assign videoOut  = video_ff;
  assign resetInN  = resetInN_ff;
  assign underrun  = underrun_ff;

  // Measuring helpers, in system clocks or line counts, saturating
  logic [15:0] vsHigh_ff;                          // Clocks frame sync high
  logic [15:0] hsHigh_ff;                          // Clocks line sync high
  logic [15:0] sinceHsRise_ff;                     // Clocks since line sync rose
  logic [15:0] sinceValFall_ff;                    // Clocks since valid fell
  logic [15:0] hsSinceVs_ff;                       // Line syncs since frame sync rose
  logic [15:0] hsSinceVal_ff;                      // Line syncs since valid fell
  logic [15:0] rstLow_ff;                          // Clocks reset held low
  logic        vsPrev_ff;
  logic        hsPrev_ff;
  logic        valPrev_ff;

  function automatic logic [15:0] satInc(input logic [15:0] c);
    satInc = (c == pvft_pkg::CNT_SAT) ? c : 16'(c + 16'h0001);
  endfunction : satInc

  // Helper counters watch only the driven pins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vsHigh_ff       <= 16'h0000;
      hsHigh_ff       <= 16'h0000;
      sinceHsRise_ff  <= pvft_pkg::CNT_SAT;
      sinceValFall_ff <= pvft_pkg::CNT_SAT;
      hsSinceVs_ff    <= 16'h0000;
      hsSinceVal_ff   <= pvft_pkg::CNT_SAT;
      rstLow_ff       <= 16'h0000;
      vsPrev_ff       <= 1'b0;
      hsPrev_ff       <= 1'b0;
      valPrev_ff      <= 1'b0;
    end else begin
      vsPrev_ff       <= video_ff.frameSync;
      hsPrev_ff       <= video_ff.lineSync;
      valPrev_ff      <= video_ff.pixelValidIn;
      vsHigh_ff       <= video_ff.frameSync ? satInc(vsHigh_ff) : 16'h0000;
      hsHigh_ff       <= video_ff.lineSync ? satInc(hsHigh_ff) : 16'h0000;
      sinceHsRise_ff  <= (video_ff.lineSync && !hsPrev_ff) ? 16'h0001 : satInc(sinceHsRise_ff);
      sinceValFall_ff <= (!video_ff.pixelValidIn && valPrev_ff) ? 16'h0001
                                                                : satInc(sinceValFall_ff);
      rstLow_ff       <= resetInN_ff ? 16'h0000 : satInc(rstLow_ff);
      if (video_ff.frameSync && !vsPrev_ff) begin
        hsSinceVs_ff <= 16'h0000;
      end else if (video_ff.lineSync && !hsPrev_ff) begin
        hsSinceVs_ff <= satInc(hsSinceVs_ff);
      end
      if (!video_ff.pixelValidIn && valPrev_ff) begin
        hsSinceVal_ff <= 16'h0000;
      end else if (video_ff.lineSync && !hsPrev_ff) begin
        hsSinceVal_ff <= satInc(hsSinceVal_ff);
      end
    end
  end

  vsync_width_a: assert property ($fell(video_ff.frameSync)
      |-> vsHigh_ff >= 16'(pvft_pkg::H_TOTAL * pvft_pkg::PIX_DIV))
    else $error("frame sync shorter than one line");

  back_porch_a: assert property ($rose(video_ff.pixelValidIn)
      |-> hsSinceVs_ff >= pvft_pkg::VBP_MIN)
    else $error("active line too soon after frame sync");

  front_porch_a: assert property (($rose(video_ff.frameSync) && hsSinceVal_ff != pvft_pkg::CNT_SAT)
      |-> hsSinceVal_ff >= 16'(pvft_pkg::VFP_MIN + 16'h0001))
    else $error("frame sync too soon after last active line");

  vert_blank_a: assert property (($rose(video_ff.pixelValidIn) && hsSinceVal_ff >= 16'h0002
      && hsSinceVal_ff != pvft_pkg::CNT_SAT)
      |-> hsSinceVal_ff >= 16'(pvft_pkg::TVB_MIN + 16'h0001))
    else $error("vertical blanking too short");

  hsync_width_a: assert property ($fell(video_ff.lineSync)
      |-> hsHigh_ff >= 16'(pvft_pkg::HSW_MIN * pvft_pkg::PIX_DIV)
       && hsHigh_ff <= 16'(pvft_pkg::HSW_MAX * pvft_pkg::PIX_DIV))
    else $error("line sync width out of range");

  hsync_to_valid_a: assert property ($rose(video_ff.pixelValidIn)
      |-> sinceHsRise_ff >= 16'(pvft_pkg::HBP_MIN * pvft_pkg::PIX_DIV))
    else $error("valid rose too soon after line sync");

  valid_to_hsync_a: assert property ($rose(video_ff.lineSync)
      |-> sinceValFall_ff >= 16'(pvft_pkg::HFP_MIN * pvft_pkg::PIX_DIV))
    else $error("line sync rose too soon after valid fell");

  line_length_a: assert property (($rose(video_ff.lineSync)
      && sinceHsRise_ff != pvft_pkg::CNT_SAT)
      |-> sinceHsRise_ff == 16'(pvft_pkg::H_TOTAL * pvft_pkg::PIX_DIV)
       && pvft_pkg::H_BLANK >= 16'(pvft_pkg::HBP_MIN + pvft_pkg::HFP_MIN))
    else $error("line period or blanking wrong");

  reset_hold_a: assert property ($rose(resetInN_ff)
      |-> rstLow_ff >= pvft_pkg::RST_CYC ##1 resetInN_ff [*8])
    else $error("controller reset released too early or dropped");

endmodule : pvft_source

//--- common/pvft_pkg.sv
// Shared constants and carriers for the video source that feeds the parallel pixel port
package pvft_pkg;

  // Clocking: system clock rate and the divider that makes the pixel clock
  localparam int CLK_MHZ = 40;                     // System clock, 25 ns period
  localparam int PIX_DIV = 2;                      // System clocks per pixel clock
  localparam int PIX_KHZ = CLK_MHZ * 1000 / PIX_DIV; // Pixel clock, 20 MHz

  // Reset to the display controller, least low time
  localparam int RST_MIN_NS = 1250;                // 1.25 us
  localparam logic [15:0] RST_CYC = 16'((RST_MIN_NS * CLK_MHZ + 999) / 1000);

  // Pixel word
  localparam int DATA_W = 24;                      // Bits per pixel
  localparam int BUF_DEPTH = 2;                    // Entries in the data buffer

  // Horizontal limits, in pixel clocks
  localparam logic [15:0] HSW_MIN = 16'h0004;      // Line sync high, least
  localparam logic [15:0] HSW_MAX = 16'h0080;      // Line sync high, most
  localparam logic [15:0] HBP_MIN = 16'h0004;      // Line sync rise to valid rise
  localparam logic [15:0] HFP_MIN = 16'h0008;      // Valid fall to line sync rise

  // Horizontal geometry chosen for this source
  localparam int LINE_KHZ = 200;                   // Line rate in kHz
  localparam logic [15:0] ACTIVE_PIXELS_PER_LINE = 16'h0040;         // Active pixels per line
  localparam logic [15:0] H_TOTAL = 16'((PIX_KHZ + LINE_KHZ - 1) / LINE_KHZ);
  localparam logic [15:0] H_BLANK = 16'(H_TOTAL - ACTIVE_PIXELS_PER_LINE);
  localparam logic [15:0] HSW = 16'h0008;          // Line sync width used
  localparam logic [15:0] HBP = 16'h000C;          // Valid starts this far after sync rise
  localparam logic [15:0] HFP = 16'(H_BLANK - HBP);

  // Vertical geometry, in lines
  localparam logic [15:0] VSW = 16'h0001;          // Frame sync high, whole lines
  localparam logic [15:0] VBP_MIN = 16'h0002;      // Frame sync to first active line
  localparam logic [15:0] VFP_MIN = 16'h0001;      // Line after last active to frame sync
  localparam int SRC_LINES = 16;                   // source_active_lines
  localparam int ARRAY_LINES = 16;                 // array_used_lines
  localparam int LINE_RATIO = (SRC_LINES + ARRAY_LINES - 1) / ARRAY_LINES;
  localparam logic [15:0] TVB_MIN = 16'(6 + 8 * ((LINE_RATIO > 1) ? LINE_RATIO : 1));
  localparam logic [15:0] ACT_LINES = 16'(SRC_LINES);
  localparam logic [15:0] VBP = 16'h0003;          // Back porch used
  localparam logic [15:0] VFP = 16'(TVB_MIN - VBP);
  localparam logic [15:0] V_TOTAL = 16'(VBP + ACT_LINES + VFP);

  // Saturation value for measuring counters
  localparam logic [15:0] CNT_SAT = 16'hFFFF;

  // Pins toward the display controller
  typedef struct packed {
    logic              frameSync;                  // Vertical sync, high active
    logic              lineSync;                   // Line sync, high active
    logic              pixelValidIn;               // Pixel-valid strobe
    logic [DATA_W-1:0] data;                       // Pixel data
  } pvft_pins_t;

endpackage : pvft_pkg

//--- hw/pvft_buf.sv
`timescale 1ns/1ps
// Two-entry style skid buffer, width and depth shape the storage
module pvft_buf #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output      logic             inReady,
  output      logic [WIDTH-1:0] outData,
  output      logic             outValid,
  input  wire logic             outReady
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_ff [DEPTH];              // Storage
  logic [PW-1:0]    wrPtr_ff;                    // Next slot to write
  logic [PW-1:0]    rdPtr_ff;                    // Oldest slot
  logic [CW-1:0]    count_ff;                    // Words held
  logic [CW-1:0]    nxt_count;
  logic             ready_ff;                    // Registered not-full, drives the ready pin
  logic             empty_ff;                    // Registered empty
  logic             push;
  logic             pop;

  // Handshakes only fire on honest flags
  assign push     = inValid & ready_ff;
  assign pop      = outReady & ~empty_ff;
  assign inReady  = ready_ff;                    // Straight from a flop, no inverter on the pin
  assign outValid = ~empty_ff;
  assign outData  = mem_ff[rdPtr_ff];

  // Pointer step wraps at depth, which need not be a power of two
  function automatic logic [PW-1:0] stepPtr(input logic [PW-1:0] p);
    stepPtr = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : stepPtr

  // Count next value
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = CW'(count_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_count = CW'(count_ff - 1'b1);
    end
  end

  // Storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  // Pointers and flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
      ready_ff <= 1'b1;
      empty_ff <= 1'b1;
    end else begin
      if (push) begin
        wrPtr_ff <= stepPtr(wrPtr_ff);
      end
      if (pop) begin
        rdPtr_ff <= stepPtr(rdPtr_ff);
      end
      count_ff <= nxt_count;
      ready_ff <= (nxt_count != CW'(DEPTH));
      empty_ff <= (nxt_count == '0);
    end
  end

endmodule : pvft_buf

//--- bench/pvft_ctrl_model.sv
`timescale 1ns/1ps
// Controller pixel port: captures pixels, counts lines, measures the raster
module pvft_ctrl_model (
  input wire logic                 pixClk,
  input wire logic                 resetInN,
  input wire pvft_pkg::pvft_pins_t videoIn
);
  int   hCnt, vCnt, pvFallAt, lastAct, actLines, frames, capCount; // Raster counters
  int   hsw, hbp, hfp, hTot, vsw, vbp, vfp, tvb, lineLen, frameLines; // Measured figures
  logic                        timingErr;  // Sticky, any figure out of bounds
  logic [pvft_pkg::DATA_W-1:0] cap [0:4095]; // Pixels in arrival order
  pvft_pkg::pvft_pins_t        prev;       // Pins at the previous sample

  // Sample on the rising pixel clock, the edge chosen after reset
  always @(posedge pixClk or negedge resetInN) begin : sample
    logic lsR, lsF, fsR, fsF, pvR, pvF;
    int   vN;
    if (!resetInN) begin
      // Held in reset: forget the raster, the source restarts it
      prev = '0;
      hCnt = 0;
      vCnt = 0;
      pvFallAt = -1;
      lastAct = -1;
      actLines = 0;
      frames = 0;
      capCount = 0;
      vfp = -1;
      timingErr = 1'b0;
    end else begin
      lsR = videoIn.lineSync & ~prev.lineSync;
      lsF = ~videoIn.lineSync & prev.lineSync;
      fsR = videoIn.frameSync & ~prev.frameSync;
      fsF = ~videoIn.frameSync & prev.frameSync;
      pvR = videoIn.pixelValidIn & ~prev.pixelValidIn;
      pvF = ~videoIn.pixelValidIn & prev.pixelValidIn;
      hCnt = hCnt + 1;
      // Line sync width, bounded both ways
      if (lsF) begin
        hsw = hCnt;
        if (hsw < 4 || hsw > 128) timingErr = 1'b1;
      end
      // Start of an active line
      if (pvR) begin
        hbp = hCnt;
        lineLen = 0;
        if (hbp < 4) timingErr = 1'b1;
        if (actLines == 0) begin
          vbp = vCnt;
          if (vbp < 2) timingErr = 1'b1;
          if (vfp >= 0) tvb = vfp + vbp;
          if (vfp >= 0 && tvb < 14) timingErr = 1'b1;
        end
        actLines = actLines + 1;
        lastAct = vCnt;
      end
      // One pixel per sampling edge while valid
      if (videoIn.pixelValidIn) begin
        if (capCount < 4096) cap[capCount] = videoIn.data;
        capCount = capCount + 1;
        lineLen = lineLen + 1;
      end
      if (pvF) pvFallAt = hCnt;
      // Line sync leading edge closes the line; frame sync restarts the count
      if (lsR) begin
        if (pvFallAt >= 0) begin
          hfp = hCnt - pvFallAt;
          if (hfp < 8) timingErr = 1'b1;
        end
        pvFallAt = -1;
        hTot = hCnt;
        hCnt = 0;
        vN = vCnt + 1;
        if (fsR) begin
          if (frames > 0) begin
            vfp = vN - (lastAct + 1);
            frameLines = actLines;
            if (vfp < 1) timingErr = 1'b1;
          end
          frames = frames + 1;
          actLines = 0;
          vN = 0;
        end
        vCnt = vN;
      end
      // Frame sync width in whole lines
      if (fsF) begin
        vsw = vCnt;
        if (vsw < 1) timingErr = 1'b1;
      end
      prev = videoIn;
    end
  end
endmodule : pvft_ctrl_model

//--- bench/pvft_source_test.sv
`timescale 1ns/1ps
// Source bench: reset pulse, buffer stall, two fed frames, then a starved pixel
module pvft_source_test;
  logic                        clk, nrst, pixValid;        // Stimulus
  logic [pvft_pkg::DATA_W-1:0] pixData;                    // Pixel word in
  logic                        pixReady, pixClkOut, resetInN, underrun; // Observed
  pvft_pkg::pvft_pins_t        videoOut;                   // Pins to the controller
  int                          numErrors, compares, k, n;  // Bookkeeping

  pvft_source dut (.clk(clk), .nrst(nrst), .pixData(pixData), .pixValid(pixValid),
                   .pixReady(pixReady), .pixClkOut(pixClkOut), .videoOut(videoOut),
                   .resetInN(resetInN), .underrun(underrun));
  pvft_ctrl_model model (.pixClk(pixClkOut), .resetInN(resetInN), .videoIn(videoOut));

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pixel word for a given position in the stream
  function automatic logic [23:0] word(int i);
    return 24'h10_0000 + 24'(i);
  endfunction : word

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic completeRun();
    $display("compares %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : completeRun

  // Bounded wait for captured pixels; a hang ends the run
  task automatic waitCap(int want);
    for (int i = 0; i < 20000; i++) begin
      @(negedge clk);
      if (model.capCount >= want) return;
    end
    numErrors++;
    $display("unexpected timeout waiting for %0d pixels", want);
    completeRun();
  endtask : waitCap

  // Controller-side pins quiet in reset, then the controller reset pulse length
  task automatic resetTest();
    @(negedge clk);
    check("rstVideo", {5'h00, videoOut}, 32'h0000_0000);
    check("rstPixClk", {31'h0000_0000, pixClkOut}, 32'h0000_0000);
    check("rstResetInN", {31'h0000_0000, resetInN}, 32'h0000_0000);
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    n = 0;
    while (n < 200 && resetInN !== 1'b1) begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end
    if (resetInN !== 1'b1) begin
      numErrors++;
      $display("unexpected timeout waiting for resetInN release");
      completeRun();
    end
    check("resetInNEdges", 32'(n), 32'(pvft_pkg::RST_CYC));
    check("resetInNLong", 32'(n * 25 >= 1250), 32'h0000_0001);
    $display("test reset done");
  endtask : resetTest

  // Two words fill the buffer before the raster drains; the third waits
  task automatic bufferTest();
    for (int i = 0; i < 2; i++) begin
      pixValid = 1'b1;
      pixData = word(i);
      check("readyFree", {31'h0000_0000, pixReady}, 32'h0000_0001);
      @(negedge clk);
    end
    pixData = word(2);
    repeat (10) begin
      check("readyFull", {31'h0000_0000, pixReady}, 32'h0000_0000);
      @(negedge clk);
    end
    $display("test buffer done");
  endtask : bufferTest

  // Feed two frames of words, compare order and every raster figure
  task automatic frameTest();
    logic rdy;
    int   ratio;
    rdy = pixReady;
    k = 2;
    for (int i = 0; i < 40000 && k < 2048; i++) begin
      @(negedge clk);
      if (rdy === 1'b1) k++;
      pixData = word(k);
      pixValid = (k < 2048);
      rdy = pixReady;
    end
    pixValid = 1'b0;
    if (k < 2048) begin
      numErrors++;
      $display("unexpected timeout feeding pixels, fed %0d", k);
      completeRun();
    end
    waitCap(2048);
    for (int i = 0; i < 2048; i++) check("pixel", {8'h00, model.cap[i]}, {8'h00, word(i)});
    check("noUnderrun", {31'h0000_0000, underrun}, 32'h0000_0000);
    ratio = (pvft_pkg::SRC_LINES + pvft_pkg::ARRAY_LINES - 1) / pvft_pkg::ARRAY_LINES;
    check("vsw", 32'(model.vsw), 32'h0000_0001);
    check("vbp", 32'(model.vbp >= 2), 32'h0000_0001);
    check("vfp", 32'(model.vfp >= 1), 32'h0000_0001);
    check("tvb", 32'(model.tvb >= 6 + 8 * ((ratio > 1) ? ratio : 1)), 32'h0000_0001);
    check("hswRange", 32'(model.hsw >= 4 && model.hsw <= 128), 32'h0000_0001);
    check("hsw", 32'(model.hsw), 32'(pvft_pkg::HSW));
    check("hbp", 32'(model.hbp >= 4), 32'h0000_0001);
    check("hfp", 32'(model.hfp >= 8), 32'h0000_0001);
    check("lineTotal", 32'(model.hTot), 32'((1000 * pvft_pkg::CLK_MHZ / pvft_pkg::PIX_DIV
          + pvft_pkg::LINE_KHZ - 1) / pvft_pkg::LINE_KHZ));
    check("blankCover", 32'(model.hTot - model.lineLen >= 4 + 8), 32'h0000_0001);
    check("lineLen", 32'(model.lineLen), 32'(pvft_pkg::ACTIVE_PIXELS_PER_LINE));
    check("frameLines", 32'(model.frameLines), 32'(pvft_pkg::SRC_LINES));
    check("timingErr", {31'h0000_0000, model.timingErr}, 32'h0000_0000);
    $display("test frame done");
  endtask : frameTest

  // Drained buffer: the raster keeps going, sends zero and flags it
  task automatic underrunTest();
    waitCap(2049);
    @(negedge clk);
    check("starvedData", {8'h00, model.cap[2048]}, 32'h0000_0000);
    check("underrun", {31'h0000_0000, underrun}, 32'h0000_0001);
    $display("test underrun done");
  endtask : underrunTest

  // Main sequence
  initial begin
    nrst = 1'b0;
    pixValid = 1'b0;
    pixData = 24'h00_0000;
    numErrors = 0;
    compares = 0;
    resetTest();
    bufferTest();
    frameTest();
    underrunTest();
    completeRun();
  end
endmodule : pvft_source_test
